// File: design/rx_fifo_consts.svh
// Register offsets, field positions and sizes of the receive FIFO control block.
`ifndef RX_FIFO_CONSTS_SVH
`define RX_FIFO_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------------
`define RXF_CTL_OFS       12'h0C0
`define RXF_IRQ_STS_OFS   12'h100
`define RXF_IRQ_MASK_OFS  12'h104

// ---------------------------------------------------------------------------
// Control and status register fields
// ---------------------------------------------------------------------------
`define RXF_EN_BIT        31
`define RXF_RST_BIT       30
`define RXF_BAD_BIT       25
`define RXF_OVF_BIT       24
`define RXF_DROP_BIT      23
`define RXF_DIS_BIT       20
`define RXF_USED_MSB      15

// ---------------------------------------------------------------------------
// Interrupt status and mask bit positions
// ---------------------------------------------------------------------------
`define RXF_IRQ_DIS       0
`define RXF_IRQ_OVF       1
`define RXF_IRQ_DROP      2

// ---------------------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------------------
`define RXF_FIFO_BYTES    12288
`define RXF_CMD_WORDS     3
`define RXF_DWORD_BYTES   16'h0004
`define RXF_DWORD_ROUND   16'h0003
`define RXF_DWORD_MASK    16'hFFFC

`endif

// File: design/rx_fifo_pkg.sv
// Types and shared arithmetic of the receive FIFO control block.
`include "rx_fifo_consts.svh"
package rx_fifo_pkg;

	typedef logic [15:0] bytes_t;

	typedef enum logic [2:0] {
		ST_OFF   = 3'b000,
		ST_SYNC  = 3'b001,
		ST_ARMED = 3'b010,
		ST_RECV  = 3'b011,
		ST_DROP  = 3'b100
	} rx_state_e;

	typedef struct packed {
		rx_state_e   st;
		logic        en;
		logic        store_bad;
		logic        ovf;
		logic        drop;
		logic        dis;
		logic [2:0]  irq_sts;
		logic [2:0]  irq_mask;
		logic        irq;
		logic        in_frame;
		bytes_t      cur;
		logic [31:0] rdata;
		logic        st_valid;
		logic [31:0] st_data;
		logic        st_sop;
		logic        st_eop;
		logic        st_commit;
		logic        st_abort;
		logic        flush;
	} ctl_s;

	typedef struct packed {
		bytes_t used;
	} used_s;

	// Rounds a byte length up to a whole number of 32-bit words.
	function automatic bytes_t dword_round(input bytes_t len);
		dword_round = (len + `RXF_DWORD_ROUND) & `RXF_DWORD_MASK;
	endfunction

endpackage

// File: design/used_if.sv
// Interface between the frame controller and its used-space accountant.
`timescale 1ns/1ns
interface used_if;
	import rx_fifo_pkg::*;
	logic   add_valid;
	bytes_t add_bytes;
	logic   sub_valid;
	bytes_t sub_bytes;
	logic   clear;
	bytes_t used;
	modport owner (input add_valid, input add_bytes, input sub_valid, input sub_bytes, input clear, output used);
	modport user  (output add_valid, output add_bytes, output sub_valid, output sub_bytes, output clear, input used);
endinterface

// File: design/used_space_counter.sv
// Byte count of occupied receive FIFO space.
`timescale 1ns/1ns
`include "rx_fifo_consts.svh"
module used_space_counter (
	input wire logic sys_clk,   // System clock.
	input wire logic resetn,    // Asynchronous reset, active low.
	used_if.owner    u          // Add, subtract and clear requests.
);
	import rx_fifo_pkg::*;

	used_s state_ff;
	used_s nxt_state;
	logic [16:0] sum;

	// ---------------------------------------------------------------------------
	// Next count
	// ---------------------------------------------------------------------------
	// Clear wins; otherwise committed frames add and drained data subtracts, floored at zero.
	always_comb begin
		nxt_state = state_ff;
		sum = {1'b0, state_ff.used} + (u.add_valid ? {1'b0, u.add_bytes} : 17'h00000);
		if (u.clear) begin
			nxt_state.used = 16'h0000;
		end else if (u.sub_valid && (17'(u.sub_bytes) > sum)) begin
			nxt_state.used = 16'h0000;
		end else begin
			nxt_state.used = 16'(sum - (u.sub_valid ? {1'b0, u.sub_bytes} : 17'h00000));
		end
	end

	// Count register.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign u.used = state_ff.used;

endmodule

// File: design/rx_fifo_control.sv
// Receive frame FIFO controller: frame admission, status flags and used-space reporting.
// What this block does
// - While receive-enable is clear, every offered frame is discarded without an abort pulse and nothing stored.
// - After enabling, storing starts with the next whole frame; a running frame is skipped.
// - Clearing enable mid-frame lets that frame finish before acceptance stops.
// - Disabled flag sets when the disable sequence completes; software writes one to clear.
// - Frames rejected while disabled never count as dropped.
// - Writing the reset bit idles the controller, empties the used count, keeps the flags and flushes the transmit pipeline remnants.
// - Store-bad-frames set keeps errored frames; clear discards them.
// - Any MAC error cause marks a frame bad.
// - Dropped flag sets when a received frame is dropped; software writes one to clear.
// - Used space grows per stored frame by its length rounded to whole words.
// - Used space also counts the command and checksum words stored per frame.
`timescale 1ns/1ns
`include "rx_fifo_consts.svh"
module rx_fifo_control #(
	parameter int FIFO_BYTES = `RXF_FIFO_BYTES, // Storage capacity in bytes.
	parameter int CMD_WORDS  = `RXF_CMD_WORDS   // Command and checksum words kept per frame.
) (
	input  wire logic                sys_clk,         // System clock, 100 MHz.
	input  wire logic                resetn,          // Asynchronous reset, active low.
	input  wire logic [11:0]         reg_addr,        // Register byte address.
	input  wire logic [31:0]         reg_wdata,       // Register write data.
	input  wire logic                reg_wr,          // Write strobe.
	input  wire logic                reg_rd,          // Read strobe.
	output logic      [31:0]         reg_rdata,       // Read data, the cycle after the strobe.
	output logic                     irq,             // Level interrupt.
	input  wire logic                rfe_valid,       // Filter engine offers a word.
	input  wire logic                rfe_sop,         // First word of a frame.
	input  wire logic                rfe_eop,         // Last word of a frame.
	input  wire logic [31:0]         rfe_data,        // Frame word.
	input  wire rx_fifo_pkg::bytes_t rfe_len,         // Frame length in bytes, with the last word.
	input  wire logic [6:0]          rfe_err,         // MAC error causes, with the last word.
	output logic                     st_valid,        // Word written to storage.
	output logic      [31:0]         st_data,         // Stored word.
	output logic                     st_sop,          // Stored word starts a frame.
	output logic                     st_eop,          // Stored word ends a frame.
	output logic                     st_commit,       // Frame complete and kept.
	output logic                     st_abort,        // Discard the partly stored frame.
	input  wire logic                utx_drain,       // Transmit path took data from storage.
	input  wire rx_fifo_pkg::bytes_t utx_drain_bytes, // Bytes taken with that pulse.
	output logic                     utx_flush,       // Flush pipeline remnants, one cycle.
	output rx_fifo_pkg::bytes_t      rx_used_bytes    // Occupied bytes.
);
	import rx_fifo_pkg::*;

	localparam bytes_t CMD_BYTES = 16'(CMD_WORDS) * `RXF_DWORD_BYTES;

	ctl_s   state_ff;
	ctl_s   nxt_state;
	used_if u ();

	logic   ctl_wr;
	logic   soft_rst;
	logic   sts_rd;
	logic   active;
	logic   bad;
	logic   no_room;
	bytes_t base;
	logic   set_dis;
	logic   set_ovf;
	logic   set_drop;

	// ---------------------------------------------------------------------------
	// Used-space accountant
	// ---------------------------------------------------------------------------
	used_space_counter u_used (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.u       (u.owner)
	);

	// ---------------------------------------------------------------------------
	// Decode and frame conditions
	// ---------------------------------------------------------------------------
	// Strobe decode and the per-word admission test.
	always_comb begin
		ctl_wr   = reg_wr && (reg_addr == `RXF_CTL_OFS);
		soft_rst = ctl_wr && reg_wdata[`RXF_RST_BIT];
		sts_rd   = reg_rd && (reg_addr == `RXF_IRQ_STS_OFS);
		active   = rfe_valid && (((state_ff.st == ST_ARMED) && rfe_sop) || (state_ff.st == ST_RECV));
		base     = (state_ff.st == ST_RECV) ? state_ff.cur : 16'h0000;
		bad      = |rfe_err;
		no_room  = ({1'b0, u.used} + {1'b0, base} + {1'b0, `RXF_DWORD_BYTES} + {1'b0, CMD_BYTES})
			> 17'(FIFO_BYTES);
	end

	// ---------------------------------------------------------------------------
	// Frame state machine and registers
	// ---------------------------------------------------------------------------
	// One pass decides the frame step, the flag events and the register access.
	always_comb begin
		nxt_state           = state_ff;
		nxt_state.st_valid  = 1'b0;
		nxt_state.st_sop    = 1'b0;
		nxt_state.st_eop    = 1'b0;
		nxt_state.st_commit = 1'b0;
		nxt_state.st_abort  = 1'b0;
		nxt_state.flush     = 1'b0;
		set_dis             = 1'b0;
		set_ovf             = 1'b0;
		set_drop            = 1'b0;
		u.add_valid         = 1'b0;
		u.add_bytes         = dword_round(rfe_len) + CMD_BYTES;
		u.sub_valid         = utx_drain;
		u.sub_bytes         = utx_drain_bytes;
		u.clear             = soft_rst;

		// Track frame boundaries whatever the state, so enabling can find the next start.
		if (rfe_valid) begin
			nxt_state.in_frame = !rfe_eop && (rfe_sop || state_ff.in_frame);
		end

		case (state_ff.st)
			ST_OFF: begin
				// Offered frames are consumed and discarded without touching the drop flag.
				if (state_ff.en) begin
					// A frame that ends in this very cycle needs no skipping.
					if (nxt_state.in_frame) begin
						nxt_state.st = ST_SYNC;
					end else begin
						nxt_state.st = ST_ARMED;
					end
				end
			end
			ST_SYNC: begin
				// Skip the frame that was running when enabled.
				if (!state_ff.en) begin
					nxt_state.st = ST_OFF;
					set_dis      = 1'b1;
				end else if (rfe_valid && rfe_eop) begin
					nxt_state.st = ST_ARMED;
				end
			end
			ST_ARMED, ST_RECV: begin
				if ((state_ff.st == ST_ARMED) && !state_ff.en) begin
					nxt_state.st = ST_OFF;
					set_dis      = 1'b1;
				end else if (active && no_room) begin
					// Frame does not fit: drop it and discard what was written.
					set_ovf            = 1'b1;
					set_drop           = 1'b1;
					nxt_state.st_abort = (state_ff.st == ST_RECV);
					nxt_state.cur      = 16'h0000;
					if (rfe_eop) begin
						nxt_state.st = state_ff.en ? ST_ARMED : ST_OFF;
						set_dis      = !state_ff.en;
					end else begin
						nxt_state.st = ST_DROP;
					end
				end else if (active && rfe_eop) begin
					// Frame ends: keep it unless it is errored and errored frames are refused.
					nxt_state.cur = 16'h0000;
					if (bad && !state_ff.store_bad) begin
						nxt_state.st_abort = 1'b1;
						set_drop           = 1'b1;
					end else begin
						nxt_state.st_valid  = 1'b1;
						nxt_state.st_data   = rfe_data;
						nxt_state.st_sop    = rfe_sop;
						nxt_state.st_eop    = 1'b1;
						nxt_state.st_commit = 1'b1;
						u.add_valid         = 1'b1;
					end
					// A disable seen during the frame takes effect only now.
					nxt_state.st = state_ff.en ? ST_ARMED : ST_OFF;
					set_dis      = !state_ff.en;
				end else if (active) begin
					nxt_state.st_valid = 1'b1;
					nxt_state.st_data  = rfe_data;
					nxt_state.st_sop   = rfe_sop;
					nxt_state.cur      = base + `RXF_DWORD_BYTES;
					nxt_state.st       = ST_RECV;
				end
			end
			ST_DROP: begin
				// Swallow the rest of an overflowed frame.
				if (rfe_valid && rfe_eop) begin
					nxt_state.st = state_ff.en ? ST_ARMED : ST_OFF;
					set_dis      = !state_ff.en;
				end
			end
			default: begin
				nxt_state.st = ST_OFF;
			end
		endcase

		// Soft reset returns the controller to idle and flushes the pipeline remnants.
		if (soft_rst) begin
			nxt_state.st        = ST_OFF;
			nxt_state.cur       = 16'h0000;
			nxt_state.st_valid  = 1'b0;
			nxt_state.st_commit = 1'b0;
			nxt_state.st_abort  = (state_ff.st == ST_RECV);
			nxt_state.flush     = 1'b1;
			u.add_valid         = 1'b0;
			set_dis             = 1'b0;
			set_ovf             = 1'b0;
			set_drop            = 1'b0;
		end

		// Control writes; write-one clears the flags, but a same-cycle event wins.
		if (ctl_wr) begin
			nxt_state.en        = reg_wdata[`RXF_EN_BIT];
			nxt_state.store_bad = reg_wdata[`RXF_BAD_BIT];
			if (reg_wdata[`RXF_OVF_BIT]) begin
				nxt_state.ovf = 1'b0;
			end
			if (reg_wdata[`RXF_DROP_BIT]) begin
				nxt_state.drop = 1'b0;
			end
			if (reg_wdata[`RXF_DIS_BIT]) begin
				nxt_state.dis = 1'b0;
			end
		end
		if (reg_wr && (reg_addr == `RXF_IRQ_MASK_OFS)) begin
			nxt_state.irq_mask = reg_wdata[2:0];
		end
		if (sts_rd) begin
			nxt_state.irq_sts = 3'h0;
		end
		if (set_dis) begin
			nxt_state.dis                  = 1'b1;
			nxt_state.irq_sts[`RXF_IRQ_DIS] = 1'b1;
		end
		if (set_ovf) begin
			nxt_state.ovf                  = 1'b1;
			nxt_state.irq_sts[`RXF_IRQ_OVF] = 1'b1;
		end
		if (set_drop) begin
			nxt_state.drop                   = 1'b1;
			nxt_state.irq_sts[`RXF_IRQ_DROP] = 1'b1;
		end
		nxt_state.irq = |(nxt_state.irq_sts & nxt_state.irq_mask);

		// Read data stand only in the cycle after the strobe; unmapped reads return zero.
		nxt_state.rdata = 32'h00000000;
		if (reg_rd) begin
			if (reg_addr == `RXF_CTL_OFS) begin
				nxt_state.rdata[`RXF_EN_BIT]            = state_ff.en;
				nxt_state.rdata[`RXF_BAD_BIT]           = state_ff.store_bad;
				nxt_state.rdata[`RXF_OVF_BIT]           = state_ff.ovf;
				nxt_state.rdata[`RXF_DROP_BIT]          = state_ff.drop;
				nxt_state.rdata[`RXF_DIS_BIT]           = state_ff.dis;
				nxt_state.rdata[`RXF_USED_MSB:0]        = u.used;
			end else if (reg_addr == `RXF_IRQ_STS_OFS) begin
				nxt_state.rdata[2:0] = state_ff.irq_sts;
			end else if (reg_addr == `RXF_IRQ_MASK_OFS) begin
				nxt_state.rdata[2:0] = state_ff.irq_mask;
			end
		end
	end

	// State register.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ---------------------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------------------
	// Every output comes straight from the state register or the accountant.
	assign reg_rdata     = state_ff.rdata;
	assign irq           = state_ff.irq;
	assign st_valid      = state_ff.st_valid;
	assign st_data       = state_ff.st_data;
	assign st_sop        = state_ff.st_sop;
	assign st_eop        = state_ff.st_eop;
	assign st_commit     = state_ff.st_commit;
	assign st_abort      = state_ff.st_abort;
	assign utx_flush     = state_ff.flush;
	assign rx_used_bytes = u.used;

	// ---------------------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------------------
	// Nothing reaches storage while the controller is off.
	property p_off_no_store;
		@(posedge sys_clk) disable iff (!resetn)
		(state_ff.st == ST_OFF) |=> !st_valid;
	endproperty
	a_off_no_store: assert property (p_off_no_store) else $error("word stored while disabled");

	// The frame running at enable time is never stored.
	property p_sync_skip;
		@(posedge sys_clk) disable iff (!resetn)
		(state_ff.st == ST_SYNC) |=> !st_valid && !st_commit;
	endproperty
	a_sync_skip: assert property (p_sync_skip) else $error("frame stored during enable sync");

	// A frame in progress keeps going after enable drops.
	property p_finish_frame;
		@(posedge sys_clk) disable iff (!resetn)
		(state_ff.st == ST_RECV) && !state_ff.en && !(rfe_valid && (rfe_eop || no_room)) && !soft_rst
			|=> (state_ff.st == ST_RECV);
	endproperty
	a_finish_frame: assert property (p_finish_frame) else $error("frame cut short by disable");

	// An idle controller that loses enable reports disabled next cycle.
	property p_dis_flag;
		@(posedge sys_clk) disable iff (!resetn)
		(state_ff.st == ST_ARMED) && !state_ff.en && !soft_rst |=> state_ff.dis && (state_ff.st == ST_OFF);
	endproperty
	a_dis_flag: assert property (p_dis_flag) else $error("disabled flag not set");

	// Traffic while off leaves the drop flag alone.
	property p_off_no_drop;
		@(posedge sys_clk) disable iff (!resetn)
		(state_ff.st == ST_OFF) && !reg_wr |=> (state_ff.drop == $past(state_ff.drop));
	endproperty
	a_off_no_drop: assert property (p_off_no_drop) else $error("drop counted while disabled");

	// Reset write flushes, idles and empties the count.
	property p_soft_reset;
		@(posedge sys_clk) disable iff (!resetn)
		soft_rst |=> utx_flush && (state_ff.st == ST_OFF) && (rx_used_bytes == 16'h0000);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

	// Refused errored frames are aborted and flagged as dropped.
	property p_bad_refused;
		@(posedge sys_clk) disable iff (!resetn)
		active && rfe_eop && !no_room && bad && !state_ff.store_bad && !soft_rst
			&& (state_ff.en || (state_ff.st == ST_RECV))
			|=> st_abort && !st_commit && state_ff.drop;
	endproperty
	a_bad_refused: assert property (p_bad_refused) else $error("bad frame not dropped");

	// A stored frame grows the count by its rounded length plus command words.
	property p_used_grow;
		@(posedge sys_clk) disable iff (!resetn)
		u.add_valid && !u.sub_valid && !u.clear
			|=> rx_used_bytes == 16'($past(rx_used_bytes) + dword_round($past(rfe_len)) + CMD_BYTES);
	endproperty
	a_used_grow: assert property (p_used_grow) else $error("used space did not grow");

	// Overflow raises both overflow and dropped flags.
	property p_overflow;
		@(posedge sys_clk) disable iff (!resetn)
		active && no_room && !soft_rst && (state_ff.en || (state_ff.st == ST_RECV))
			|=> state_ff.ovf && state_ff.drop;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not flagged");

	// Draining lowers the count by the drained bytes.
	property p_used_drain;
		@(posedge sys_clk) disable iff (!resetn)
		utx_drain && !u.add_valid && !u.clear && (utx_drain_bytes <= rx_used_bytes)
			|=> rx_used_bytes == 16'($past(rx_used_bytes) - $past(utx_drain_bytes));
	endproperty
	a_used_drain: assert property (p_used_drain) else $error("used space did not shrink");

endmodule

// File: sim/rx_path_model.sv
// Model of the filter engine that offers frames and the transmit path that drains storage.
`timescale 1ns/1ns
module rx_path_model (
	input  wire logic           sys_clk,         // System clock.
	output logic                rfe_valid,       // Word offered.
	output logic                rfe_sop,         // First word.
	output logic                rfe_eop,         // Last word.
	output logic [31:0]         rfe_data,        // Frame word.
	output rx_fifo_pkg::bytes_t rfe_len,         // Frame length with the last word.
	output logic [6:0]          rfe_err,         // Error causes with the last word.
	output logic                utx_drain,       // Drain pulse.
	output rx_fifo_pkg::bytes_t utx_drain_bytes  // Bytes drained.
);
	import rx_fifo_pkg::*;

	// Idle values at time zero.
	initial begin
		{rfe_valid, rfe_sop, rfe_eop, utx_drain} = 4'h0;
		rfe_data = 32'h0;
		rfe_len = 16'h0;
		rfe_err = 7'h00;
		utx_drain_bytes = 16'h0;
	end

	// Offers one whole frame, one word a cycle; length and causes are valid only with the last word.
	task automatic send(input bytes_t len, input logic [6:0] err);
		int nw;
		nw = (int'(len) + 3) / 4;
		for (int w = 0; w < nw; w++) begin
			@(posedge sys_clk);
			rfe_valid <= 1'b1;
			rfe_sop <= (w == 0);
			rfe_eop <= (w == nw - 1);
			rfe_data <= $urandom;
			rfe_len <= (w == nw - 1) ? len : bytes_t'($urandom);
			rfe_err <= (w == nw - 1) ? err : 7'h00;
		end
		@(posedge sys_clk);
		{rfe_valid, rfe_sop, rfe_eop} <= 3'h0;
		rfe_data <= ~rfe_data;
		rfe_len <= ~rfe_len;
	endtask

	// Takes bytes out of storage in a single pulse.
	task automatic drain(input bytes_t n);
		@(posedge sys_clk);
		utx_drain <= 1'b1;
		utx_drain_bytes <= n;
		@(posedge sys_clk);
		utx_drain <= 1'b0;
		utx_drain_bytes <= ~n;
	endtask
endmodule

// File: sim/rx_fifo_control_tb.sv
// Self-checking testbench of the receive FIFO controller.
`timescale 1ns/1ns
`include "rx_fifo_consts.svh"
module rx_fifo_control_tb;
	import rx_fifo_pkg::*;
	localparam int          FIFO_BYTES = 256;
	localparam int          CMD_WORDS  = 3;
	localparam logic [31:0] EN         = 32'h80000000;
	localparam logic [31:0] BAD        = 32'h02000000;
	localparam logic [31:0] DROP       = 32'h00800000;
	localparam logic [31:0] DIS        = 32'h00100000;
	logic        sys_clk, resetn, reg_wr, reg_rd, irq, utx_drain, utx_flush;
	logic        rfe_valid, rfe_sop, rfe_eop, st_valid, st_sop, st_eop, st_commit, st_abort;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rfe_data, st_data, d, prev_data;
	logic [6:0]  rfe_err;
	bytes_t      rfe_len, utx_drain_bytes, rx_used_bytes, len, exp_used;
	int          err_count, cmp_count, cycles, n_word, n_commit, n_abort, n_flush, w0, n_mark, m0;

	// Clock of 100 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	rx_fifo_control #(.FIFO_BYTES(FIFO_BYTES), .CMD_WORDS(CMD_WORDS)) DUT (
		.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .rfe_valid(rfe_valid), .rfe_sop(rfe_sop),
		.rfe_eop(rfe_eop), .rfe_data(rfe_data), .rfe_len(rfe_len), .rfe_err(rfe_err), .st_valid(st_valid),
		.st_data(st_data), .st_sop(st_sop), .st_eop(st_eop), .st_commit(st_commit), .st_abort(st_abort),
		.utx_drain(utx_drain), .utx_drain_bytes(utx_drain_bytes), .utx_flush(utx_flush),
		.rx_used_bytes(rx_used_bytes));

	rx_path_model far (
		.sys_clk(sys_clk), .rfe_valid(rfe_valid), .rfe_sop(rfe_sop), .rfe_eop(rfe_eop), .rfe_data(rfe_data),
		.rfe_len(rfe_len), .rfe_err(rfe_err), .utx_drain(utx_drain), .utx_drain_bytes(utx_drain_bytes));

	// Counts storage events on the falling edge, checks each stored word and cuts a hang short.
	always @(negedge sys_clk) begin
		n_word += (st_valid === 1'b1);
		if (st_valid === 1'b1) begin
			chk(st_data, prev_data, "stored word");
		end
		prev_data = rfe_data;
		n_mark += (st_sop === 1'b1) + (st_eop === 1'b1);
		n_commit += (st_commit === 1'b1);
		n_abort += (st_abort === 1'b1);
		n_flush += (utx_flush === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			$display("MISMATCH at %0t: run did not finish", $time);
			end_sim();
		end
	end

	// Expected growth of used space for one kept frame.
	function automatic bytes_t grow(input bytes_t n);
		grow = ((n + 16'h0003) & 16'hFFFC) + 16'(CMD_WORDS * 4);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp, input string what);
		cmp_count++;
		if (got != exp) begin
			err_count++;
			$display("MISMATCH at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic chk_ctl(input logic [31:0] exp);
		rd(`RXF_CTL_OFS, d);
		chk(d, exp, "control");
	endtask

	task automatic settle();
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	task automatic frame(input bytes_t n, input logic [6:0] err);
		far.send(n, err);
		settle();
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence of tests.
	initial begin
		{resetn, reg_wr, reg_rd} = 3'h0;
		reg_addr = 12'h000;
		reg_wdata = 32'h0;
		void'($urandom(32'hC0FE));
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		chk_ctl(32'h0);
		rd(12'h004, d);
		chk(d, 32'h0, "unmapped");
		rd(`RXF_IRQ_MASK_OFS, d);
		chk(d, 32'h0, "mask");
		done("reset");
		frame(16'h0014, 7'h00);
		frame(16'h0007, 7'h7F);
		chk_n(n_word, 0, "words while off");
		chk_ctl(32'h0);
		done("disabled");
		// Enable lands in the middle of a frame.
		fork
			frame(16'h0018, 7'h00);
			begin
				repeat (2) @(posedge sys_clk);
				wr(`RXF_CTL_OFS, EN);
			end
		join
		chk_n(n_word, 0, "skipped frame");
		for (int i = 0; i < 8; i++) begin
			len = bytes_t'(1 + $urandom_range(63));
			w0 = n_word;
			m0 = n_mark;
			frame(len, 7'h00);
			exp_used = grow(len);
			chk(32'(rx_used_bytes), 32'(exp_used), "used");
			chk_n(n_word - w0, (int'(len) + 3) / 4, "words");
			chk_n(n_mark - m0, 2, "frame marks");
			far.drain(exp_used - 16'h0004);
			settle();
			chk(32'(rx_used_bytes), 32'h4, "drain");
			far.drain(16'h0100);
			settle();
			chk(32'(rx_used_bytes), 32'h0, "floor");
		end
		chk_n(n_commit, 8, "commits");
		done("random frames");
		for (int i = 0; i < 7; i++) begin
			w0 = n_abort;
			frame(16'h0008, 7'(1 << i));
			chk_n(n_abort - w0, 1, "bad abort");
			chk_ctl(EN | DROP);
			wr(`RXF_CTL_OFS, EN | DROP);
			chk_ctl(EN);
		end
		wr(`RXF_CTL_OFS, EN | BAD);
		frame(16'h0008, 7'h7F);
		chk(32'(rx_used_bytes), 32'h14, "bad kept");
		far.drain(16'h0014);
		settle();
		done("bad frames");
		wr(`RXF_CTL_OFS, EN);
		w0 = n_abort;
		frame(16'h012C, 7'h00);
		chk_n(n_abort - w0, 1, "overflow abort");
		chk_ctl(EN | 32'h01800000);
		wr(`RXF_CTL_OFS, EN | 32'h01800000);
		done("overflow");
		rd(`RXF_IRQ_STS_OFS, d);
		chk(d, 32'h6, "sticky status");
		rd(`RXF_IRQ_STS_OFS, d);
		chk(d, 32'h0, "status cleared");
		wr(`RXF_IRQ_MASK_OFS, 32'h4);
		frame(16'h0008, 7'h01);
		chk(32'(irq), 32'h1, "irq raised");
		rd(`RXF_IRQ_STS_OFS, d);
		settle();
		chk(32'(irq), 32'h0, "irq cleared");
		wr(`RXF_IRQ_MASK_OFS, 32'h0);
		frame(16'h0008, 7'h01);
		chk(32'(irq), 32'h0, "irq masked");
		wr(`RXF_CTL_OFS, EN | DROP);
		done("interrupt");
		// Disable lands in the middle of a frame, which still completes.
		w0 = n_commit;
		fork
			frame(16'h0018, 7'h00);
			begin
				repeat (2) @(posedge sys_clk);
				wr(`RXF_CTL_OFS, 32'h0);
			end
		join
		chk_n(n_commit - w0, 1, "frame finished");
		chk_ctl(DIS | 32'(grow(16'h0018)));
		w0 = n_word;
		frame(16'h0008, 7'h00);
		chk_n(n_word - w0, 0, "words after disable");
		done("disable");
		wr(`RXF_CTL_OFS, 32'h40000000);
		settle();
		chk_n(n_flush, 1, "flush pulse");
		chk_ctl(DIS);
		wr(`RXF_CTL_OFS, DIS);
		chk_ctl(32'h0);
		done("reset bit");
		end_sim();
	end
endmodule
